// ==== logic/sbst_fsm_if.sv ====
// carrier between the port core and its state machine
`timescale 1ns/10ps

interface sbst_fsm_if;
  logic step;
  logic tmsBit;
  sbst_pkg::sbst_state_t state;

  modport fsm (
    input step,
    input tmsBit,
    output state
  );

  modport core (
    output step,
    output tmsBit,
    input state
  );
endinterface

// ==== logic/sbst_params.svh ====
// constants of the serial boundary-scan test port
`ifndef SBST_PARAMS_SVH
`define SBST_PARAMS_SVH

// ****************************************
// register lengths
// ****************************************
`define SBST_IR_LEN 3
`define SBST_ID_LEN 32
`define SBST_BSR_LEN 71

// ****************************************
// instruction codes
// ****************************************
`define SBST_INS_EXTEST 3'h0
`define SBST_INS_IDCODE 3'h1
`define SBST_INS_SAMPLEZ 3'h2
`define SBST_INS_SAMPLE 3'h4
`define SBST_INS_BYPASS 3'h7

// pattern loaded in instruction capture, low two bits are 01
`define SBST_IR_CAPTURE 3'h1

// ****************************************
// identification
// ****************************************
// arbitrary identity value, bit 0 must stay 1
`define SBST_ID_CODE 32'h0ABCD001

// ****************************************
// reset values
// ****************************************
`define SBST_SYNC_RST 1'h1
`define SBST_TDO_RST 1'h0

`endif

// ==== logic/sbst_pkg.sv ====
// types shared by the boundary-scan test port modules
package sbst_pkg;

  // ****************************************
  // test controller states
  // ****************************************
  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEL_DR,
    ST_CAP_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPD_DR,
    ST_SEL_IR,
    ST_CAP_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPD_IR
  } sbst_state_t;

  // ****************************************
  // data register in the serial path
  // ****************************************
  typedef enum logic [1:0] {
    SEL_BYPASS,
    SEL_ID,
    SEL_BOUNDARY
  } sbst_sel_t;

endpackage

// ==== logic/sbst_tap.sv ====
// serial boundary-scan test port core
// Function
// - inputs taken on test clock rise, outputs change only on its fall
// - mode select steers the state machine; unconnected it reads high only while the sync flops are held in reset
// - serial input enters register msb, serial output leaves from lsb
// - serial output driven only in shift states, otherwise released
// - five high mode-select samples reset test logic, memory unaffected
// - power-up reset puts test logic in reset with output released
// - one data register in the path, chosen by the instruction alone
// - three-bit instruction register loads identify code at reset
// - instruction capture loads 01 into the two low bits
// - bypass is one bit, cleared when bypass is executed
// - under bypass in data shift the single bit forms the path
// - boundary register captures the I/O ring and shifts under sample types
// - identify captures a fixed 32-bit code and shifts it out
// - new instruction takes effect only in instruction update
// - all-zero code acts like sample and forces memory outputs off
// - sample-high-z shifts boundary register and forces memory outputs off
// - sample snapshots pins; data update acts like pause
// - no injection into memory and no preload of I/O buffers
// - codes 000 external test, 001 identify, 010 sample high-z
// - boundary register is 71 bits long
// - identify code bit 0 reads 1
`timescale 1ns/10ps
`include "sbst_params.svh"

module sbst_tap #(
  parameter int BSR_LEN = `SBST_BSR_LEN,
  // arbitrary identity value
  parameter logic [`SBST_ID_LEN-1:0] ID_CODE = `SBST_ID_CODE
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic tckPin,
  input wire logic tmsPin,
  input wire logic tdiPin,
  input wire logic [BSR_LEN-1:0] ioRing,
  output logic tdoOut,
  output logic tdoOe,
  output logic memOutHighZ
);
  import sbst_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic tckS1_r;
  logic tckS2_r;
  logic tckS3_r;
  logic tmsS1_r;
  logic tmsS2_r;
  logic tdiS1_r;
  logic tdiS2_r;
  logic [BSR_LEN-1:0] ringS1_r;
  logic [BSR_LEN-1:0] ringS2_r;
  logic tckRise;
  logic tckFall;

  // sync flops preset high so select and data read high until pin values pass through after reset
  always_ff @(posedge clock) begin
    if (srst) begin
      tmsS1_r <= `SBST_SYNC_RST;
      tmsS2_r <= `SBST_SYNC_RST;
      tdiS1_r <= `SBST_SYNC_RST;
      tdiS2_r <= `SBST_SYNC_RST;
    end else begin
      tmsS1_r <= tmsPin;
      tmsS2_r <= tmsS1_r;
      tdiS1_r <= tdiPin;
      tdiS2_r <= tdiS1_r;
    end
  end

  // clock held low keeps every edge detect quiet
  always_ff @(posedge clock) begin
    if (srst) begin
      tckS1_r <= 1'h0;
      tckS2_r <= 1'h0;
      tckS3_r <= 1'h0;
    end else begin
      tckS1_r <= tckPin;
      tckS2_r <= tckS1_r;
      tckS3_r <= tckS2_r;
    end
  end

  // ring bits may be mid-transition; second flop bounds metastability only
  always_ff @(posedge clock) begin
    ringS1_r <= ioRing;
    ringS2_r <= ringS1_r;
  end

  assign tckRise = tckS2_r & ~tckS3_r;
  assign tckFall = ~tckS2_r & tckS3_r;

  // ****************************************
  // state machine
  // ****************************************
  sbst_fsm_if fsmIf ();
  sbst_state_t state;

  assign fsmIf.step = tckRise;
  assign fsmIf.tmsBit = tmsS2_r;
  assign state = fsmIf.state;

  sbst_tap_fsm uFsm (
    .clock(clock),
    .srst(srst),
    .ctl(fsmIf)
  );

  // ****************************************
  // instruction register
  // ****************************************
  logic [`SBST_IR_LEN-1:0] irShift_r;
  logic [`SBST_IR_LEN-1:0] irActive_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      irShift_r <= `SBST_INS_IDCODE;
    end else if (tckRise) begin
      case (state)
        ST_CAP_IR: irShift_r <= `SBST_IR_CAPTURE;
        ST_SHIFT_IR: irShift_r <= {tdiS2_r, irShift_r[`SBST_IR_LEN-1:1]};
        default: irShift_r <= irShift_r;
      endcase
    end
  end

  // reserved codes fall to bypass; the controller must not load them
  always_ff @(posedge clock) begin
    if (srst) begin
      irActive_r <= `SBST_INS_IDCODE;
    end else if (state == ST_RESET) begin
      irActive_r <= `SBST_INS_IDCODE;
    end else if (tckRise && state == ST_UPD_IR) begin
      irActive_r <= irShift_r;
    end
  end

  // ****************************************
  // data register selection
  // ****************************************
  sbst_sel_t drSel;

  always_comb begin
    case (irActive_r)
      `SBST_INS_IDCODE: drSel = SEL_ID;
      `SBST_INS_EXTEST: drSel = SEL_BOUNDARY;
      `SBST_INS_SAMPLEZ: drSel = SEL_BOUNDARY;
      `SBST_INS_SAMPLE: drSel = SEL_BOUNDARY;
      default: drSel = SEL_BYPASS;
    endcase
  end

  // ****************************************
  // bypass bit
  // ****************************************
  logic bypass_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      bypass_r <= 1'h0;
    end else if (tckRise && drSel == SEL_BYPASS) begin
      case (state)
        ST_CAP_DR: bypass_r <= 1'h0;
        ST_SHIFT_DR: bypass_r <= tdiS2_r;
        default: bypass_r <= bypass_r;
      endcase
    end
  end

  // ****************************************
  // identification register
  // ****************************************
  logic [`SBST_ID_LEN-1:0] idShift_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      idShift_r <= ID_CODE;
    end else if (tckRise && drSel == SEL_ID) begin
      case (state)
        ST_CAP_DR: idShift_r <= {ID_CODE[`SBST_ID_LEN-1:1], 1'h1};
        ST_SHIFT_DR: idShift_r <= {tdiS2_r, idShift_r[`SBST_ID_LEN-1:1]};
        default: idShift_r <= idShift_r;
      endcase
    end
  end

  // ****************************************
  // boundary register
  // ****************************************
  logic [BSR_LEN-1:0] bsr_r;

  // capture only; update has no output stage, so nothing reaches the memory
  always_ff @(posedge clock) begin
    if (srst) begin
      bsr_r <= '0;
    end else if (tckRise && drSel == SEL_BOUNDARY) begin
      case (state)
        ST_CAP_DR: bsr_r <= ringS2_r;
        ST_SHIFT_DR: bsr_r <= {tdiS2_r, bsr_r[BSR_LEN-1:1]};
        ST_UPD_DR: bsr_r <= bsr_r;
        default: bsr_r <= bsr_r;
      endcase
    end
  end

  // ****************************************
  // serial output, updated on the falling edge
  // ****************************************
  logic tdoBit;

  always_comb begin
    if (state == ST_SHIFT_IR) begin
      tdoBit = irShift_r[0];
    end else begin
      case (drSel)
        SEL_ID: tdoBit = idShift_r[0];
        SEL_BOUNDARY: tdoBit = bsr_r[0];
        default: tdoBit = bypass_r;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tdoOe <= `SBST_TDO_RST;
      tdoOut <= `SBST_TDO_RST;
    end else if (tckFall) begin
      tdoOe <= (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);
      tdoOut <= tdoBit;
    end
  end

  // ****************************************
  // memory output release
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      memOutHighZ <= 1'h0;
    end else if (tckFall) begin
      memOutHighZ <= (irActive_r == `SBST_INS_EXTEST) || (irActive_r == `SBST_INS_SAMPLEZ);
    end
  end
endmodule

// ==== logic/sbst_tap_fsm.sv ====
// sixteen-state test controller sequencing
`timescale 1ns/10ps

module sbst_tap_fsm (
  input wire logic clock,
  input wire logic srst,
  sbst_fsm_if.fsm ctl
);
  import sbst_pkg::*;

  sbst_state_t state_r;
  sbst_state_t state_nxt;

  // ****************************************
  // next state from sampled mode select
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET: state_nxt = ctl.tmsBit ? ST_RESET : ST_IDLE;
      ST_IDLE: state_nxt = ctl.tmsBit ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_nxt = ctl.tmsBit ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = ctl.tmsBit ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_nxt = ctl.tmsBit ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_nxt = ctl.tmsBit ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_nxt = ctl.tmsBit ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_nxt = ctl.tmsBit ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_nxt = ctl.tmsBit ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_nxt = ctl.tmsBit ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_nxt = ctl.tmsBit ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_nxt = ctl.tmsBit ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_nxt = ctl.tmsBit ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_nxt = ctl.tmsBit ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_nxt = ctl.tmsBit ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: state_nxt = ctl.tmsBit ? ST_SEL_DR : ST_IDLE;
      default: state_nxt = ST_RESET;
    endcase
  end

  // five high samples reach reset from any state
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= ST_RESET;
    end else if (ctl.step) begin
      state_r <= state_nxt;
    end
  end

  assign ctl.state = state_r;
endmodule

// ==== verif/sbst_ctl_model.sv ====
// board test controller model for the serial test port
`timescale 1ns/10ps

module sbst_ctl_model (
  input wire logic clock,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // test clock parked low between frames, data lines at pull-up level
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end

  // one 64 ns test clock; tdo taken at the rise, clock parked low after the fall
  task automatic bit_cyc(input logic m, input logic d, output logic o);
    @(posedge clock);
    tms <= m;
    tdi <= d;
    @(posedge clock);
    tck <= 1'h1;
    o = tdo;
    repeat (4) @(posedge clock);
    tck <= 1'h0;
    repeat (2) @(posedge clock);
  endtask

  task automatic tap_reset();
    logic o;
    repeat (5) bit_cyc(1'h1, 1'h1, o);
    bit_cyc(1'h0, 1'h1, o);
  endtask

  // from idle: capture, shift n bits, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
    logic o;
    dout = '0;
    bit_cyc(1'h1, 1'h1, o);
    if (ir) bit_cyc(1'h1, 1'h1, o);
    bit_cyc(1'h0, 1'h1, o);
    bit_cyc(1'h0, 1'h1, o);
    for (int i = 0; i < n; i++) begin
      bit_cyc(i == n - 1, din[i], o);
      dout[i] = o;
    end
    bit_cyc(1'h1, 1'h1, o);
    bit_cyc(1'h0, 1'h1, o);
  endtask
endmodule

// ==== verif/sbst_tap_assertions.sv ====
// pin-level assertions for the serial test port
`timescale 1ns/10ps
`include "sbst_params.svh"

module sbst_tap_assertions #(
  parameter int BSR_LEN = `SBST_BSR_LEN,
  parameter logic [`SBST_ID_LEN-1:0] ID_CODE = `SBST_ID_CODE
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic tckPin,
  input wire logic tmsPin,
  input wire logic tdiPin,
  input wire logic [BSR_LEN-1:0] ioRing,
  input wire logic tdoOut,
  input wire logic tdoOe,
  input wire logic memOutHighZ
);
  logic tckPrev_r;
  logic [2:0] highCnt_r;
  logic [3:0] lowCnt_r;

  // ****************************************
  // helper counters
  // ****************************************
  always_ff @(posedge clock) begin
    tckPrev_r <= tckPin;
  end

  // raw pin rises; the sync delay only shifts the count in time
  always_ff @(posedge clock) begin
    if (srst) begin
      highCnt_r <= 3'h0;
    end else if (tckPin && !tckPrev_r) begin
      highCnt_r <= !tmsPin ? 3'h0 : (highCnt_r == 3'h5 ? 3'h5 : highCnt_r + 3'h1);
    end
  end

  // reset so a clock parked low from power-up is counted, not left unknown
  always_ff @(posedge clock) begin
    if (srst) begin
      lowCnt_r <= 4'h0;
    end else begin
      lowCnt_r <= tckPin ? 4'h0 : (lowCnt_r == 4'hF ? 4'hF : lowCnt_r + 4'h1);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  // ****************************************
  // assertions
  // ****************************************
  a_tdo_on_fall: assert property ($changed(tdoOut) |-> !$past(tckPin, 3))
    else $error("serial out changed away from a test clock fall");
  a_oe_on_fall: assert property ($changed(tdoOe) |-> !$past(tckPin, 3))
    else $error("serial out enable changed away from a fall");
  a_hz_on_fall: assert property ($changed(memOutHighZ) |-> !$past(tckPin, 3))
    else $error("memory output disable changed away from a fall");
  a_reset_quiet: assert property ($fell(srst) |-> !tdoOe && !tdoOut && !memOutHighZ)
    else $error("outputs not quiet after reset");
  a_five_high: assert property ($rose(highCnt_r == 3'h5) |-> ##[1:12] (!memOutHighZ && !tdoOe))
    else $error("five high mode samples did not reset the port");
  a_oe_stands: assert property ($rose(tdoOe) |-> tdoOe [*6])
    else $error("serial out enable dropped too early");
  a_hz_stands: assert property ($rose(memOutHighZ) |-> memOutHighZ [*6])
    else $error("memory output disable dropped too early");
  a_tdo_stands: assert property ($changed(tdoOut) |=> $stable(tdoOut) [*5])
    else $error("serial out did not hold a full half period");
  a_idle_quiet: assert property (lowCnt_r == 4'hF |-> $stable({tdoOut, tdoOe, memOutHighZ}))
    else $error("outputs moved with test clock parked low");

  c_oe_on: cover property ($rose(tdoOe));
  c_hz_on: cover property ($rose(memOutHighZ));
  c_five_high: cover property ($rose(highCnt_r == 3'h5));
endmodule

bind sbst_tap sbst_tap_assertions #(.BSR_LEN(BSR_LEN), .ID_CODE(ID_CODE)) u_chk (
  .clock(clock), .srst(srst), .tckPin(tckPin), .tmsPin(tmsPin), .tdiPin(tdiPin),
  .ioRing(ioRing), .tdoOut(tdoOut), .tdoOe(tdoOe), .memOutHighZ(memOutHighZ));

// ==== verif/sbst_tap_tb_top.sv ====
// self-checking bench for the serial test port
`timescale 1ns/10ps
`include "sbst_params.svh"

module sbst_tap_tb_top;
  logic clock = 1'h0;
  logic srst = 1'h1;
  logic tckPin, tmsPin, tdiPin, tdoOut, tdoOe, memOutHighZ, tdoLine;
  logic [`SBST_BSR_LEN-1:0] ioRing = '0;
  logic [127:0] dout;
  int miscompares = 0;
  int cmpCount = 0;
  int cycles = 0;

  always #4 clock = ~clock;

  // released serial out reads inverted so a missing enable shows
  assign tdoLine = tdoOe ? tdoOut : ~tdoOut;

  sbst_tap #(.BSR_LEN(`SBST_BSR_LEN)) u_dut (.clock(clock), .srst(srst), .tckPin(tckPin),
    .tmsPin(tmsPin), .tdiPin(tdiPin), .ioRing(ioRing), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .memOutHighZ(memOutHighZ));
  sbst_ctl_model u_ctl (.clock(clock), .tck(tckPin), .tms(tmsPin), .tdi(tdiPin), .tdo(tdoLine));

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    cmpCount++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // outputs move three clocks after the last fall; wait until they settle
  task automatic load_ir(input logic [2:0] code);
    u_ctl.scan(1'h1, 3, code, dout);
    check(dout, 128'h1);
    repeat (2) @(negedge clock);
  endtask

  task automatic test_idcode();
    check({tdoOe, memOutHighZ}, 2'h0);
    repeat (20) @(negedge clock);
    check({tdoOe, memOutHighZ, tdoOut}, 3'h0);
    u_ctl.tap_reset();
    u_ctl.scan(1'h0, 32, '0, dout);
    check(dout, `SBST_ID_CODE);
  endtask

  // reserved codes are never sent
  task automatic test_codes();
    logic [2:0] codes [4] = '{3'h0, 3'h2, 3'h4, 3'h7};
    logic [70:0] pat;
    for (int k = 0; k < 4; k++) begin
      pat = 71'h3A123456789ABCDEF0 >> k;
      @(posedge clock);
      ioRing <= pat;
      load_ir(codes[k]);
      check(memOutHighZ, codes[k] < 3'h3);
      if (k < 3) begin
        u_ctl.scan(1'h0, 71, '1, dout);
        check(dout, pat);
        u_ctl.scan(1'h0, 71, '0, dout);
        check(dout, pat);
      end else begin
        u_ctl.scan(1'h0, 8, 128'hA5, dout);
        check(dout, 128'h4A);
      end
    end
  endtask

  task automatic test_tap_reset();
    load_ir(3'h2);
    check(memOutHighZ, 1'h1);
    u_ctl.tap_reset();
    repeat (2) @(negedge clock);
    check({tdoOe, memOutHighZ}, 2'h0);
    u_ctl.scan(1'h0, 32, '0, dout);
    check(dout, `SBST_ID_CODE);
  endtask

  task automatic completeRun();
    if (miscompares == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // run takes about 4850 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      completeRun();
    end
  end

  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'h0;
    repeat (3) @(posedge clock);
    test_idcode();
    test_codes();
    test_tap_reset();
    completeRun();
  end
endmodule
